// ===== rtl/eil_params.svh
// Purpose: constants for the external interrupt line unit
// Assumes: 250 MHz clock, one cycle per 4 ns
// Notes: times are kept in microseconds or milliseconds, counts derived
`ifndef EIL_PARAMS_SVH
`define EIL_PARAMS_SVH

`define EIL_CLK_MHZ 250
`define EIL_OUT_PW_US 16'h0005
`define EIL_IN_PW_US 16'h0005
`define EIL_SPACING_US 16'h01F4
`define EIL_TICK_MS 10
`define EIL_TICK_CYCLES (`EIL_TICK_MS * 1000 * `EIL_CLK_MHZ)
`define EIL_MAX_BACKOFF 4'h8
`define EIL_LINES_RESET 4'h0

`endif

// ===== rtl/eil_pkg.sv
// Purpose: types shared by the external interrupt line unit
// Assumes: nothing beyond the params header
// Notes: stuck-input supervisor states
package eil_pkg;
  typedef enum logic [1:0] {
    EIL_IDLE = 2'b00, // waiting for first interrupt
    EIL_ARMED = 2'b01, // pulse seen, spacing window open
    EIL_HOLD = 2'b10 // input treated as stuck, receipt masked
  } eil_stuck_e;
endpackage

// ===== rtl/eil_us_timer.sv
// Purpose: microsecond tick generator
// Assumes: clock frequency in MHz is a whole number
// Notes: one-cycle pulse every microsecond
`timescale 1ns/10ps
`include "eil_params.svh"
module eil_us_timer #(
  parameter int CLK_MHZ = `EIL_CLK_MHZ
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, high
  output logic us_tick // one pulse per microsecond
);
  logic [9:0] cnt_reg;
  wire cnt_wrap = (cnt_reg == 10'(CLK_MHZ - 1));

  // -----------------------------------------------
  // free running divider
  // -----------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 10'h000;
      us_tick <= 1'b0;
    end else begin
      cnt_reg <= cnt_wrap ? 10'h000 : cnt_reg + 10'h001;
      us_tick <= cnt_wrap;
    end
  end
endmodule

// ===== rtl/eil_line_drv.sv
// Purpose: one outgoing interrupt line with set, clear and timed pulse
// Assumes: microsecond tick from the shared timer
// Notes: a pulse of width zero still lasts one tick boundary at most
`timescale 1ns/10ps
module eil_line_drv (
  input wire logic clk, // system clock
  input wire logic rst, // async reset, high
  input wire logic sel, // this line chosen by mask
  input wire logic do_set, // set-high request
  input wire logic do_clr, // set-low request
  input wire logic do_pulse, // pulse request
  input wire logic [15:0] width_us, // pulse width
  input wire logic us_tick, // microsecond tick
  output logic line // line level, active high
);
  logic [15:0] left_reg;
  logic pulsing_reg;
  wire pulse_done = pulsing_reg && us_tick && (left_reg <= 16'h0001);

  // -----------------------------------------------
  // level and pulse timer; set and clear cancel a pulse
  // -----------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line <= 1'b0;
      pulsing_reg <= 1'b0;
      left_reg <= 16'h0000;
    end else if (sel && do_set) begin
      line <= 1'b1;
      pulsing_reg <= 1'b0;
    end else if (sel && do_clr) begin
      line <= 1'b0;
      pulsing_reg <= 1'b0;
    end else if (sel && do_pulse) begin
      line <= 1'b1;
      pulsing_reg <= 1'b1;
      left_reg <= width_us;
    end else if (pulse_done) begin
      line <= 1'b0;
      pulsing_reg <= 1'b0;
    end else if (pulsing_reg && us_tick) begin
      left_reg <= left_reg - 16'h0001;
    end
  end
endmodule

// ===== rtl/eil_top.sv
// Purpose: external interrupt line unit, four outputs and two inputs
// Assumes: all inputs synchronous to CLOCK; requests are one-cycle pulses
// Notes: control bits are plain ports, no register bus
`timescale 1ns/10ps
`include "eil_params.svh"
module eil_top
  import eil_pkg::*;
#(
  parameter int LINES = 4,
  parameter int TICK_CYCLES = `EIL_TICK_CYCLES,
  parameter logic [3:0] MAX_BACKOFF = `EIL_MAX_BACKOFF
) (
  input wire logic CLOCK, // system clock, 250 MHz
  input wire logic RST, // async reset, high
  input wire logic [3:0] LINE_MASK, // lines chosen by a request
  input wire logic PULSE_LINES_REQUEST, // pulse masked lines
  input wire logic ASSERT_LINES_REQUEST, // drive masked lines high
  input wire logic DEASSERT_LINES_REQUEST, // drive masked lines low
  input wire logic SET_OUTPUT_PULSE_WIDTH, // load output width
  input wire logic SET_INPUT_PULSE_WIDTH, // load input width
  input wire logic SET_MIN_PULSE_SPACING, // load spacing
  input wire logic [15:0] WIDTH_DATA, // microseconds for loads
  input wire logic INPUT_RECEIVE_ENABLE, // enable input receipt
  input wire logic INPUT_RECEIVE_DISABLE, // disable input receipt
  input wire logic [1:0] IN_LINES, // incoming lines, active high
  input wire logic IRQ_ACK, // host finished with one interrupt
  output logic [3:0] OUT_LINES, // outgoing lines, active high
  output logic EXT_IRQ, // level interrupt to host
  output logic [15:0] GET_OUTPUT_PULSE_WIDTH, // output width readback
  output logic [15:0] GET_INPUT_PULSE_WIDTH, // input width readback
  output logic [15:0] GET_MIN_PULSE_SPACING, // spacing readback
  output logic RECEIVE_ENABLED, // software enable state
  output logic STUCK_HOLD, // receipt masked for stuck input
  output logic REQ_ERROR // request seen with empty mask
);
  // -----------------------------------------------
  // request decode
  // -----------------------------------------------
  wire mask_ok = |LINE_MASK;
  wire any_req = PULSE_LINES_REQUEST | ASSERT_LINES_REQUEST | DEASSERT_LINES_REQUEST;
  wire do_pulse = PULSE_LINES_REQUEST & mask_ok;
  wire do_set = ASSERT_LINES_REQUEST & mask_ok;
  wire do_clr = DEASSERT_LINES_REQUEST & mask_ok;
  wire us_tick;
  wire [3:0] line_q;

  eil_us_timer #(
    .CLK_MHZ(`EIL_CLK_MHZ)
  ) u_timer (
    .clk(CLOCK),
    .rst(RST),
    .us_tick(us_tick)
  );

  // -----------------------------------------------
  // one driver per line, each independent
  // -----------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < LINES; gi++) begin : g_line
      eil_line_drv u_drv (
        .clk(CLOCK),
        .rst(RST),
        .sel(LINE_MASK[gi]),
        .do_set(do_set),
        .do_clr(do_clr),
        .do_pulse(do_pulse),
        .width_us(GET_OUTPUT_PULSE_WIDTH),
        .us_tick(us_tick),
        .line(line_q[gi])
      );
    end
  endgenerate

  // the drivers already end in flops; this stage keeps the port a flop
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      OUT_LINES <= `EIL_LINES_RESET;
      REQ_ERROR <= 1'b0;
    end else begin
      OUT_LINES <= line_q;
      REQ_ERROR <= any_req & ~mask_ok;
    end
  end

  // -----------------------------------------------
  // programmable widths, readable back
  // -----------------------------------------------
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      GET_OUTPUT_PULSE_WIDTH <= `EIL_OUT_PW_US;
      GET_INPUT_PULSE_WIDTH <= `EIL_IN_PW_US;
      GET_MIN_PULSE_SPACING <= `EIL_SPACING_US;
    end else begin
      if (SET_OUTPUT_PULSE_WIDTH)
        GET_OUTPUT_PULSE_WIDTH <= WIDTH_DATA;
      if (SET_INPUT_PULSE_WIDTH)
        GET_INPUT_PULSE_WIDTH <= WIDTH_DATA;
      if (SET_MIN_PULSE_SPACING)
        GET_MIN_PULSE_SPACING <= WIDTH_DATA;
    end
  end

  // -----------------------------------------------
  // receipt enable; disable wins if both arrive together
  // -----------------------------------------------
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST)
      RECEIVE_ENABLED <= 1'b0;
    else if (INPUT_RECEIVE_DISABLE)
      RECEIVE_ENABLED <= 1'b0;
    else if (INPUT_RECEIVE_ENABLE)
      RECEIVE_ENABLED <= 1'b1;
  end

  // -----------------------------------------------
  // stuck-input supervisor
  // an ack ends one interrupt; if another ack comes with the input still high
  // before the spacing has passed, it is held off for growing numbers of ticks
  // -----------------------------------------------
  eil_stuck_e st_reg, st_next;
  logic [15:0] space_reg, space_next;
  logic [31:0] tick_reg, tick_next;
  logic [3:0] hold_reg, hold_next; // ticks in current hold
  logic [3:0] back_reg, back_next; // hold length, grows each retry until it reaches MAX_BACKOFF
  wire in_any = |IN_LINES;
  wire live = RECEIVE_ENABLED & (st_reg != EIL_HOLD);
  wire irq_now = live & in_any;
  wire tick_end = (tick_reg == 32'(TICK_CYCLES - 1));
  wire space_open = (space_reg < GET_MIN_PULSE_SPACING);

  always_comb begin
    st_next = st_reg;
    space_next = space_reg;
    tick_next = tick_reg;
    hold_next = hold_reg;
    back_next = back_reg;
    unique case (st_reg)
      EIL_IDLE: begin
        if (IRQ_ACK && irq_now) begin
          st_next = EIL_ARMED;
          space_next = 16'h0000;
        end
      end
      EIL_ARMED: begin
        if (us_tick && space_open)
          space_next = space_reg + 16'h0001;
        if (IRQ_ACK && irq_now && space_open) begin
          st_next = EIL_HOLD;
          tick_next = 32'h0;
          hold_next = 4'h0;
        end else if (IRQ_ACK && irq_now) begin
          space_next = 16'h0000;
        end else if (!space_open) begin
          st_next = EIL_IDLE;
          back_next = 4'h1;
        end
      end
      EIL_HOLD: begin
        tick_next = tick_end ? 32'h0 : tick_reg + 32'h1;
        if (tick_end) begin
          if (hold_reg + 4'h1 >= back_reg) begin
            // retest: still asserted means stuck again, for one tick longer up to MAX_BACKOFF
            if (in_any && RECEIVE_ENABLED) begin
              hold_next = 4'h0;
              back_next = (back_reg < MAX_BACKOFF) ? back_reg + 4'h1 : back_reg;
            end else begin
              st_next = EIL_IDLE;
              back_next = 4'h1;
            end
          end else begin
            hold_next = hold_reg + 4'h1;
          end
        end
      end
      default: st_next = EIL_IDLE;
    endcase
  end

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      st_reg <= EIL_IDLE;
      space_reg <= 16'h0000;
      tick_reg <= 32'h0;
      hold_reg <= 4'h0;
      back_reg <= 4'h1;
    end else begin
      st_reg <= st_next;
      space_reg <= space_next;
      tick_reg <= tick_next;
      hold_reg <= hold_next;
      back_reg <= back_next;
    end
  end

  // -----------------------------------------------
  // level interrupt output, no record of which input
  // -----------------------------------------------
  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      EXT_IRQ <= 1'b0;
      STUCK_HOLD <= 1'b0;
    end else begin
      EXT_IRQ <= RECEIVE_ENABLED & (st_next != EIL_HOLD) & in_any;
      STUCK_HOLD <= (st_next == EIL_HOLD);
    end
  end
endmodule

// ===== dv/eil_top_properties.sv
// Purpose: port-level properties of the interrupt line unit
// Assumes: one clock; requests are one cycle long
// Notes: latencies follow the hand-over timing
`timescale 1ns/10ps
module eil_props (
  input wire logic CLOCK, // clock
  input wire logic RST, // reset
  input wire logic [3:0] LINE_MASK, // mask
  input wire logic PULSE_LINES_REQUEST, // pulse
  input wire logic ASSERT_LINES_REQUEST, // set
  input wire logic DEASSERT_LINES_REQUEST, // clear
  input wire logic SET_OUTPUT_PULSE_WIDTH, // load
  input wire logic [15:0] WIDTH_DATA, // data
  input wire logic INPUT_RECEIVE_ENABLE, // on
  input wire logic INPUT_RECEIVE_DISABLE, // off
  input wire logic [1:0] IN_LINES, // inputs
  input wire logic [3:0] OUT_LINES, // outputs
  input wire logic EXT_IRQ, // irq
  input wire logic [15:0] GET_OUTPUT_PULSE_WIDTH, // width
  input wire logic RECEIVE_ENABLED, // enabled
  input wire logic REQ_ERROR // refused
);
  // ----------
  // properties
  // ----------
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // set beats clear beats pulse, so each antecedent excludes the stronger ones
  wire set_go = ASSERT_LINES_REQUEST && |LINE_MASK;
  wire clr_go = DEASSERT_LINES_REQUEST && |LINE_MASK && !ASSERT_LINES_REQUEST;
  wire pul_go = PULSE_LINES_REQUEST && |LINE_MASK && !ASSERT_LINES_REQUEST && !clr_go;
  wire any_req = PULSE_LINES_REQUEST || ASSERT_LINES_REQUEST || DEASSERT_LINES_REQUEST;
  property p_set;
    set_go |-> ##2 (OUT_LINES & $past(LINE_MASK, 2)) == $past(LINE_MASK, 2);
  endproperty
  a_set: assert property (p_set) else $error("set lines not high");
  property p_clr; clr_go |-> ##2 (OUT_LINES & $past(LINE_MASK, 2)) == 4'h0; endproperty
  a_clr: assert property (p_clr) else $error("cleared lines not low");
  property p_pul;
    pul_go |-> ##2 (OUT_LINES & $past(LINE_MASK, 2)) == $past(LINE_MASK, 2);
  endproperty
  a_pul: assert property (p_pul) else $error("pulsed lines not raised");
  property p_err; any_req && LINE_MASK == 4'h0 |=> REQ_ERROR; endproperty
  a_err: assert property (p_err) else $error("empty mask not refused");
  property p_en; INPUT_RECEIVE_ENABLE && !INPUT_RECEIVE_DISABLE |=> RECEIVE_ENABLED; endproperty
  a_en: assert property (p_en) else $error("receipt not enabled");
  property p_dis; INPUT_RECEIVE_DISABLE |=> !RECEIVE_ENABLED ##1 !EXT_IRQ; endproperty
  a_dis: assert property (p_dis) else $error("interrupt while disabled");
  // the irq flop samples enable and inputs at the same edge, one cycle back
  property p_irq; EXT_IRQ |-> $past(RECEIVE_ENABLED) && $past(|IN_LINES); endproperty
  a_irq: assert property (p_irq) else $error("interrupt without cause");
  property p_opw; SET_OUTPUT_PULSE_WIDTH |=> GET_OUTPUT_PULSE_WIDTH == $past(WIDTH_DATA); endproperty
  a_opw: assert property (p_opw) else $error("pulse width readback wrong");
  c_set: cover property (set_go);
  c_irq: cover property (EXT_IRQ);
  c_err: cover property (REQ_ERROR);
endmodule
bind eil_top eil_props u_props (.*);

// ===== dv/eil_far.sv
// Purpose: far system wired to the interrupt lines
// Assumes: bench changes levels at the falling edge
// Notes: only line 0 pulses are timed
`timescale 1ns/10ps
module eil_far (
  input wire logic CLOCK, // system clock
  input wire logic [3:0] OUT_LINES, // lines from the unit
  input wire logic [1:0] want, // levels asked for
  output logic [1:0] IN_LINES, // lines into the unit
  output logic [15:0] hi_w // last high run on line 0
);
  logic [15:0] run;
  // ---------
  // behaviour
  // ---------
  // plain levels, held until the bench changes them
  assign IN_LINES = want;
  initial begin
    hi_w = 16'h0000;
    run = 16'h0000;
  end
  // length of each high run, in clocks, seen from outside
  always @(posedge CLOCK) begin
    if (OUT_LINES[0]) begin
      run <= run + 16'h0001;
    end else if (run != 16'h0000) begin
      hi_w <= run;
      run <= 16'h0000;
    end
  end
endmodule

// ===== dv/tb.sv
// Purpose: self-checking bench for the interrupt line unit
// Assumes: stuck tick shortened to 50 clocks
// Notes: drivers queue notes; a watcher compares them
`timescale 1ns/10ps
module tb;
  logic clk, rst;
  logic [8:0] r;
  logic [3:0] mask, lines, m, out_l;
  logic [1:0] want, in_l;
  logic [15:0] wdata, d, hi_w, opw, ipw, spw;
  logic irq, rcv, stk, rerr;
  logic [19:0] e;
  logic [19:0] q[$];
  int err_count, num_checks, seed, k, i, b;
  event chk;
  string nm [9] = '{"out", "opw", "ipw", "spw", "rcv", "irq", "rerr", "stuck", "pulse"};
  eil_top #(.TICK_CYCLES(50)) u_dut (
    .CLOCK(clk), .RST(rst), .LINE_MASK(mask), .PULSE_LINES_REQUEST(r[0]),
    .ASSERT_LINES_REQUEST(r[1]), .DEASSERT_LINES_REQUEST(r[2]),
    .SET_OUTPUT_PULSE_WIDTH(r[3]), .SET_INPUT_PULSE_WIDTH(r[4]),
    .SET_MIN_PULSE_SPACING(r[5]), .WIDTH_DATA(wdata), .INPUT_RECEIVE_ENABLE(r[6]),
    .INPUT_RECEIVE_DISABLE(r[7]), .IN_LINES(in_l), .IRQ_ACK(r[8]), .OUT_LINES(out_l),
    .EXT_IRQ(irq), .GET_OUTPUT_PULSE_WIDTH(opw), .GET_INPUT_PULSE_WIDTH(ipw),
    .GET_MIN_PULSE_SPACING(spw), .RECEIVE_ENABLED(rcv), .STUCK_HOLD(stk), .REQ_ERROR(rerr));
  eil_far u_far (.CLOCK(clk), .OUT_LINES(out_l), .want(want), .IN_LINES(in_l), .hi_w(hi_w));
  // -------
  // helpers
  // -------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // 2 us pulse on a free 1 us tick: 250 to 500 clocks, two spare
  function automatic logic [15:0] seen(input logic [3:0] s);
    case (s)
      4'h0: seen = {12'h000, out_l};
      4'h1: seen = opw;
      4'h2: seen = ipw;
      4'h3: seen = spw;
      4'h4: seen = {15'h0000, rcv};
      4'h5: seen = {15'h0000, irq};
      4'h6: seen = {15'h0000, rerr};
      4'h7: seen = {15'h0000, stk};
      default: seen = {15'h0000, (hi_w >= 16'h00FA) && (hi_w <= 16'h01F6)};
    endcase
  endfunction
  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string n);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic results();
    if (err_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic note(input logic [3:0] s, input logic [15:0] v, input int n);
    repeat (n) @(negedge clk);
    q.push_back({s, v});
    ->chk;
  endtask
  // one-cycle request, held across exactly one rising edge
  task automatic req(input int bit_no, input logic [3:0] mk, input logic [15:0] dt);
    @(negedge clk);
    mask = mk;
    wdata = dt;
    r = 9'h001 << bit_no;
    @(negedge clk);
    r = 9'h000;
  endtask
  // bounded wait; running out counts as a mismatch and ends the run
  task automatic wait_for(input logic [3:0] s, input logic [15:0] v);
    for (i = 0; i < 5000 && seen(s) !== v; i++) @(negedge clk);
    if (seen(s) !== v) begin
      check(seen(s), v, nm[s]);
      results();
    end
  endtask
  // watcher drains every pending note against the outputs as they stand
  always @(chk) begin
    while (q.size() > 0) begin
      e = q.pop_front();
      check(seen(e[19:16]), e[15:0], nm[e[19:16]]);
    end
  end
  // --------
  // sequence
  // --------
  initial begin
    seed = 32'hD24D;
    rst = 1'b1;
    r = 9'h000;
    mask = 4'h0;
    wdata = 16'h0000;
    want = 2'h0;
    lines = 4'h0;
    err_count = 0;
    num_checks = 0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    note(4'h0, 16'h0000, 0);
    note(4'h4, 16'h0000, 0);
    note(4'h1, 16'h0005, 0);
    note(4'h3, 16'h01F4, 0);
    // random set and clear; lines outside the mask must keep their level
    for (k = 0; k < 12; k++) begin
      b = $random(seed) & 1;
      m = 4'($random(seed));
      if (m == 4'h0) m = 4'h1;
      req(1 + b, m, 16'h0000);
      lines = b ? (lines & ~m) : (lines | m);
      note(4'h0, {12'h000, lines}, 2);
    end
    req(1, 4'h0, 16'h0000);
    note(4'h6, 16'h0001, 0);
    note(4'h0, {12'h000, lines}, 2);
    req(3, 4'h0, 16'h0002);
    note(4'h1, 16'h0002, 0);
    d = 16'($random(seed));
    req(4, 4'h0, d);
    note(4'h2, d, 0);
    req(5, 4'h0, 16'h0009);
    note(4'h3, 16'h0009, 0);
    req(2, 4'hF, 16'h0000);
    req(0, 4'h1, 16'h0000);
    note(4'h0, 16'h0001, 1);
    wait_for(4'h0, 16'h0000);
    note(4'h8, 16'h0001, 1);
    // inputs: refused while disabled, then level-held and ORed
    want = 2'h1;
    note(4'h5, 16'h0000, 8);
    req(6, 4'h0, 16'h0000);
    note(4'h4, 16'h0001, 0);
    note(4'h5, 16'h0001, 2);
    want = 2'h2;
    note(4'h5, 16'h0001, 4);
    want = 2'h0;
    note(4'h5, 16'h0000, 3);
    want = 2'h3;
    note(4'h5, 16'h0001, 3);
    req(7, 4'h0, 16'h0000);
    note(4'h5, 16'h0000, 2);
    // stuck input: quick re-entry masks, release once the line drops
    req(6, 4'h0, 16'h0000);
    note(4'h5, 16'h0001, 3);
    req(8, 4'h0, 16'h0000);
    req(8, 4'h0, 16'h0000);
    wait_for(4'h7, 16'h0001);
    note(4'h5, 16'h0000, 2);
    // still high at the first retest: held again, now for two ticks
    note(4'h7, 16'h0001, 58);
    want = 2'h0;
    // a one-tick hold would have let go by now
    note(4'h7, 16'h0001, 45);
    wait_for(4'h7, 16'h0000);
    want = 2'h1;
    note(4'h5, 16'h0001, 3);
    results();
  end
endmodule
